//--- hw/mbr_pkg.sv
// constants, types and register map of the modbus reference mapper
package mbr_pkg;

	// register byte offsets on the axi4-lite slave
	localparam logic [7:0] OFS_CFG    = 8'h00;
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_WDATA  = 8'h08;
	localparam logic [7:0] OFS_RESULT = 8'h0c;
	localparam logic [7:0] OFS_CTRL   = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// field positions
	localparam int unsigned CFG_PROF_LSB = 0;
	localparam int unsigned CFG_SYS_BIT  = 2;
	localparam int unsigned CMD_FC_LSB   = 0;
	localparam int unsigned CMD_ADDR_LSB = 8;
	localparam int unsigned CMD_QTY_LSB  = 24;
	localparam int unsigned RES_EXC_LSB  = 16;
	localparam int unsigned RES_DONE_BIT = 31;

	// reset values
	localparam logic [31:0] CFG_RST   = 32'h0000_0000;
	localparam logic [31:0] CMD_RST   = 32'h0000_0000;
	localparam logic [31:0] WDATA_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [5:0]  RELAY_RST = 6'h00;

	// profile selector values
	localparam logic [1:0] PSEL_LIMITED  = 2'h0;
	localparam logic [1:0] PSEL_EXTENDED = 2'h1;
	localparam logic [1:0] PSEL_FULL     = 2'h2;

	// function codes
	localparam logic [7:0] FC_READ_COIL   = 8'h01;
	localparam logic [7:0] FC_READ_DI     = 8'h02;
	localparam logic [7:0] FC_READ_HREG   = 8'h03;
	localparam logic [7:0] FC_READ_IREG   = 8'h04;
	localparam logic [7:0] FC_FORCE_COIL  = 8'h05;
	localparam logic [7:0] FC_WRITE_HREG  = 8'h06;
	localparam logic [7:0] FC_FORCE_COILS = 8'h0f;
	localparam logic [7:0] FC_WRITE_HREGS = 8'h10;
	localparam logic [7:0] FC_RW_HREGS    = 8'h17;

	// exception codes
	localparam logic [7:0] EXC_NONE  = 8'h00;
	localparam logic [7:0] EXC_FUNC  = 8'h01;
	localparam logic [7:0] EXC_ADDR  = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;

	localparam logic [15:0] COIL_ON  = 16'hff00;
	localparam logic [15:0] COIL_OFF = 16'h0000;

	// reference space sizes (zero-based message addresses)
	localparam int unsigned N_RELAY = 6;
	localparam int unsigned N_DIN   = 6;
	localparam logic [16:0] N_BITS  = 17'h00026;
	localparam logic [15:0] RELAY_BASE = 16'h0020;
	localparam logic [15:0] N_IREG  = 16'h0002;
	localparam logic [4:0]  MAX_QTY = 5'h10;
	localparam logic [4:0]  ONE_QTY = 5'h01;

	// holding registers owned by this block
	localparam logic [15:0] HREG_CTRL_LO = 16'h0000;
	localparam logic [15:0] HREG_CTRL_HI = 16'h0001;
	localparam logic [15:0] HREG_STAT_LO = 16'h0002;
	localparam logic [15:0] HREG_STAT_HI = 16'h0003;

	// control and status bits that carry meaning per profile
	localparam logic [31:0] CMASK_LIMITED  = 32'h0000_08ef;
	localparam logic [31:0] CMASK_FULL     = 32'h0000_0cff;
	localparam logic [31:0] CMASK_EXTENDED = 32'h000f_fff7;
	localparam logic [31:0] CMASK_BYPASS   = 32'h0000_08ef;
	localparam logic [31:0] SMASK_STD      = 32'h0000_1fff;
	localparam logic [31:0] SMASK_EXTENDED = 32'hfc1f_ffff;

	typedef enum logic [1:0]
	{
		limited_std_profile,
		extended_32bit_profile,
		full_std_profile,
		fixed_bypass_profile
	} mbr_profile_e;

	typedef struct packed
	{
		logic ramp_stop_n;
		logic coast_stop_n;
		logic quick_stop_n;
		logic start;
		logic stop;
		logic reverse;
		logic fault_reset;
		logic ramp_hold;
		logic ramp_in_zero;
		logic ramp_out_zero;
		logic remote_cmd;
		logic external_location_two;
		logic run_disable;
		logic stop_by_ramp;
		logic stop_emergency;
		logic stop_by_coast;
		logic ramp_set_two;
		logic local_lock_request;
		logic second_torque_limit;
		logic fieldbus_local_control;
		logic fieldbus_local_reference;
		logic start_inhibit_one;
		logic start_inhibit_two;
	} mbr_drive_cmd_s;

	typedef struct packed
	{
		logic        done;
		logic [7:0]  exc;
		logic [15:0] data;
	} mbr_result_s;

endpackage : mbr_pkg

//--- hw/mbr_sync.sv
// two-flop synchroniser for asynchronous pin inputs
module mbr_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output      logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : mbr_sync

//--- hw/mbr_reference_map.sv
// modbus reference-space mapper with axi4-lite command registers
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
module mbr_reference_map (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [7:0]              awaddr,
	input  wire logic                    awvalid,
	output      logic                    awready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	input  wire logic                    wvalid,
	output      logic                    wready,
	output      logic [1:0]              bresp,
	output      logic                    bvalid,
	input  wire logic                    bready,
	input  wire logic [7:0]              araddr,
	input  wire logic                    arvalid,
	output      logic                    arready,
	output      logic [31:0]             rdata,
	output      logic [1:0]              rresp,
	output      logic                    rvalid,
	input  wire logic                    rready,
	input  wire logic [31:0]             status_word,
	input  wire logic [15:0]             analog_in_one,
	input  wire logic [15:0]             analog_in_two,
	input  wire logic [5:0]              digital_in,
	output      logic [31:0]             control_word,
	output      logic [5:0]              relay_out,
	output      mbr_pkg::mbr_drive_cmd_s drive_cmd,
	output      mbr_pkg::mbr_profile_e   active_profile
);

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	logic [7:0]              awaddr_q;
	logic [31:0]             wdata_q;
	logic [3:0]              wstrb_q;
	logic                    aw_held_q, w_held_q, bvalid_q, rvalid_q;
	logic [1:0]              bresp_q, rresp_q;
	logic [31:0]             rdata_q, cfg_q, cmd_q, wreg_q, ctrl_q;
	logic                    go_q;
	logic [5:0]              relay_q;
	mbr_pkg::mbr_result_s    res_q, res_d;
	mbr_pkg::mbr_drive_cmd_s dcmd_d, dcmd_q;
	logic [31:0]             ctrl_d;
	logic [5:0]              relay_d;
	logic [5:0]              din_sync;

	mbr_sync #(.W(mbr_pkg::N_DIN)) u_din_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (digital_in),
		.q       (din_sync)
	);

	// write path: address and data are taken independently, then joined
	wire do_write = aw_held_q && w_held_q && !bvalid_q;
	wire [31:0] bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire sel_cfg  = awaddr_q == mbr_pkg::OFS_CFG;
	wire sel_cmd  = awaddr_q == mbr_pkg::OFS_CMD;
	wire sel_wreg = awaddr_q == mbr_pkg::OFS_WDATA;
	wire wr_known = sel_cfg || sel_cmd || sel_wreg;

	assign awready = !aw_held_q && !bvalid_q;
	assign wready  = !w_held_q && !bvalid_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = !rvalid_q;
	assign rvalid  = rvalid_q;
	assign rresp   = rresp_q;
	assign rdata   = rdata_q;

	// profile resolution
	wire [1:0] psel    = cfg_q[mbr_pkg::CFG_PROF_LSB +: 2];
	wire       sys_set = cfg_q[mbr_pkg::CFG_SYS_BIT];
	mbr_pkg::mbr_profile_e prof;
	assign prof = sys_set ? mbr_pkg::fixed_bypass_profile :
		(psel == mbr_pkg::PSEL_EXTENDED) ?
			mbr_pkg::extended_32bit_profile :
		(psel == mbr_pkg::PSEL_FULL) ? mbr_pkg::full_std_profile :
		mbr_pkg::limited_std_profile;
	wire is_ext = prof == mbr_pkg::extended_32bit_profile;
	wire [31:0] cmask =
		(prof == mbr_pkg::extended_32bit_profile) ? mbr_pkg::CMASK_EXTENDED :
		(prof == mbr_pkg::full_std_profile) ? mbr_pkg::CMASK_FULL :
		(prof == mbr_pkg::fixed_bypass_profile) ? mbr_pkg::CMASK_BYPASS :
		mbr_pkg::CMASK_LIMITED;
	wire [31:0] stat_m = status_word &
		(is_ext ? mbr_pkg::SMASK_EXTENDED : mbr_pkg::SMASK_STD);

	// bit images: control word then relays, status word then inputs
	wire [37:0] coil_img = {relay_q, ctrl_q};
	wire [37:0] din_img  = {din_sync, stat_m};

	// command decode; the set is implied by the function code alone
	wire [7:0]  fc   = cmd_q[mbr_pkg::CMD_FC_LSB +: 8];
	wire [15:0] madr = cmd_q[mbr_pkg::CMD_ADDR_LSB +: 16];
	wire [4:0]  qty  = cmd_q[mbr_pkg::CMD_QTY_LSB +: 5];
	wire [15:0] wd   = wreg_q[15:0];
	wire fc_coil = fc == mbr_pkg::FC_READ_COIL ||
		fc == mbr_pkg::FC_FORCE_COIL || fc == mbr_pkg::FC_FORCE_COILS;
	wire fc_hreg = fc == mbr_pkg::FC_READ_HREG ||
		fc == mbr_pkg::FC_WRITE_HREG || fc == mbr_pkg::FC_WRITE_HREGS ||
		fc == mbr_pkg::FC_RW_HREGS;
	wire fc_ok = fc_coil || fc_hreg || fc == mbr_pkg::FC_READ_DI ||
		fc == mbr_pkg::FC_READ_IREG;
	wire fc_multi = fc == mbr_pkg::FC_READ_COIL ||
		fc == mbr_pkg::FC_READ_DI || fc == mbr_pkg::FC_FORCE_COILS;
	wire qty_ok  = qty != 5'h00 && qty <= mbr_pkg::MAX_QTY;
	wire bits_in = ({1'b0, madr} + {12'h000, qty}) <= mbr_pkg::N_BITS;
	wire one_in  = {1'b0, madr} < mbr_pkg::N_BITS;
	// the upper word halves exist only with the 32-bit profile
	wire hr_in = madr == mbr_pkg::HREG_CTRL_LO ||
		madr == mbr_pkg::HREG_STAT_LO ||
		(is_ext && (madr == mbr_pkg::HREG_CTRL_HI ||
		madr == mbr_pkg::HREG_STAT_HI));
	wire hr_wr   = fc != mbr_pkg::FC_READ_HREG;
	wire hr_stat = madr == mbr_pkg::HREG_STAT_LO ||
		madr == mbr_pkg::HREG_STAT_HI;
	wire hr_hi   = madr == mbr_pkg::HREG_CTRL_HI;
	wire [31:0] hr_new = hr_hi ? {wd, ctrl_q[15:0]} : {ctrl_q[31:16], wd};
	wire [31:0] hr_newm = hr_new & cmask;
	wire [15:0] hr_rd =
		(madr == mbr_pkg::HREG_CTRL_LO) ? ctrl_q[15:0] :
		(madr == mbr_pkg::HREG_CTRL_HI) ? ctrl_q[31:16] :
		(madr == mbr_pkg::HREG_STAT_LO) ? stat_m[15:0] : stat_m[31:16];

	always_comb
	begin
		logic [37:0] img;
		logic [5:0]  idx;
		img     = coil_img;
		idx     = 6'h00;
		res_d   = res_q;
		ctrl_d  = ctrl_q;
		relay_d = relay_q;
		if (go_q)
		begin
			res_d.done = 1'b1;
			res_d.exc  = mbr_pkg::EXC_NONE;
			res_d.data = 16'h0000;
			if (!fc_ok)
				res_d.exc = mbr_pkg::EXC_FUNC;
			else if (fc_multi)
			begin
				if (!qty_ok)
					res_d.exc = mbr_pkg::EXC_VALUE;
				else if (!bits_in)
					res_d.exc = mbr_pkg::EXC_ADDR;
				else
				begin
					for (int i = 0; i < 16; i++)
					begin
						idx = madr[5:0] + 6'(i);
						if (5'(i) < qty)
						begin
							if (fc == mbr_pkg::FC_READ_DI)
								res_d.data[i] = din_img[idx];
							else if (fc == mbr_pkg::FC_READ_COIL)
								res_d.data[i] = coil_img[idx];
							else
								img[idx] = wd[i];
						end
					end
					ctrl_d  = img[31:0];
					relay_d = img[37:32];
				end
			end
			else if (fc == mbr_pkg::FC_FORCE_COIL)
			begin
				if (!one_in)
					res_d.exc = mbr_pkg::EXC_ADDR;
				else if (wd != mbr_pkg::COIL_ON && wd != mbr_pkg::COIL_OFF)
					res_d.exc = mbr_pkg::EXC_VALUE;
				else
				begin
					img[madr[5:0]] = wd == mbr_pkg::COIL_ON;
					ctrl_d  = img[31:0];
					relay_d = img[37:32];
				end
			end
			else if (qty != mbr_pkg::ONE_QTY)
				res_d.exc = mbr_pkg::EXC_VALUE;
			else if (fc == mbr_pkg::FC_READ_IREG)
			begin
				if (madr >= mbr_pkg::N_IREG)
					res_d.exc = mbr_pkg::EXC_ADDR;
				else
					res_d.data = madr[0] ? analog_in_two : analog_in_one;
			end
			else if (!hr_in || (hr_wr && hr_stat))
				res_d.exc = mbr_pkg::EXC_ADDR;
			else if (hr_wr)
			begin
				ctrl_d = hr_new;
				if (fc == mbr_pkg::FC_RW_HREGS)
					res_d.data = hr_hi ? hr_newm[31:16] : hr_newm[15:0];
			end
			else
				res_d.data = hr_rd;
		end
	end

	// per-profile meaning of the control word; unused fields stay passive
	always_comb
	begin
		dcmd_d = '0;
		dcmd_d.ramp_stop_n  = 1'b1;
		dcmd_d.coast_stop_n = 1'b1;
		dcmd_d.quick_stop_n = 1'b1;
		unique case (prof)
			mbr_pkg::extended_32bit_profile:
			begin
				dcmd_d.stop                     = ctrl_q[0];
				dcmd_d.start                    = ctrl_q[1];
				dcmd_d.reverse                  = ctrl_q[2];
				dcmd_d.fault_reset              = ctrl_q[4];
				dcmd_d.external_location_two    = ctrl_q[5];
				dcmd_d.run_disable              = ctrl_q[6];
				dcmd_d.stop_by_ramp             = ctrl_q[7];
				dcmd_d.stop_emergency           = ctrl_q[8];
				dcmd_d.stop_by_coast            = ctrl_q[9];
				dcmd_d.ramp_set_two             = ctrl_q[10];
				dcmd_d.ramp_out_zero            = ctrl_q[11];
				dcmd_d.ramp_hold                = ctrl_q[12];
				dcmd_d.ramp_in_zero             = ctrl_q[13];
				dcmd_d.local_lock_request       = ctrl_q[14];
				dcmd_d.second_torque_limit      = ctrl_q[15];
				dcmd_d.fieldbus_local_control   = ctrl_q[16];
				dcmd_d.fieldbus_local_reference = ctrl_q[17];
				dcmd_d.start_inhibit_one        = ctrl_q[18];
				dcmd_d.start_inhibit_two        = ctrl_q[19];
			end
			mbr_pkg::limited_std_profile, mbr_pkg::full_std_profile,
			mbr_pkg::fixed_bypass_profile:
			begin
				dcmd_d.ramp_stop_n           = ctrl_q[0];
				dcmd_d.coast_stop_n          = ctrl_q[1];
				dcmd_d.quick_stop_n          = ctrl_q[2];
				dcmd_d.start                 = ctrl_q[3];
				dcmd_d.ramp_hold             = ctrl_q[5];
				dcmd_d.ramp_in_zero          = ctrl_q[6];
				dcmd_d.fault_reset           = ctrl_q[7];
				dcmd_d.external_location_two = ctrl_q[11];
				dcmd_d.ramp_out_zero         = ctrl_q[4];
				dcmd_d.remote_cmd            = ctrl_q[10];
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			cfg_q     <= mbr_pkg::CFG_RST;
			cmd_q     <= mbr_pkg::CMD_RST;
			wreg_q    <= mbr_pkg::WDATA_RST;
			go_q      <= 1'b0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= wdata;
				wstrb_q  <= wstrb;
			end
			go_q <= do_write && sel_cmd;
			if (do_write)
			begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_known ? RESP_OKAY : RESP_SLVERR;
				if (sel_cfg)
					cfg_q <= (cfg_q & ~bmask) | (wdata_q & bmask);
				if (sel_cmd)
					cmd_q <= (cmd_q & ~bmask) | (wdata_q & bmask);
				if (sel_wreg)
					wreg_q <= (wreg_q & ~bmask) | (wdata_q & bmask);
			end
			else if (bready)
				bvalid_q <= 1'b0;
		end
	end

	wire [7:0] ra = araddr;
	wire rd_known = ra == mbr_pkg::OFS_CFG || ra == mbr_pkg::OFS_CMD ||
		ra == mbr_pkg::OFS_WDATA || ra == mbr_pkg::OFS_RESULT ||
		ra == mbr_pkg::OFS_CTRL || ra == mbr_pkg::OFS_STATUS;
	wire [31:0] rd_mux =
		(ra == mbr_pkg::OFS_CFG) ? cfg_q :
		(ra == mbr_pkg::OFS_CMD) ? cmd_q :
		(ra == mbr_pkg::OFS_WDATA) ? wreg_q :
		(ra == mbr_pkg::OFS_RESULT) ? {res_q.done, 7'h00, res_q.exc,
			res_q.data} :
		(ra == mbr_pkg::OFS_CTRL) ? ctrl_q :
		(ra == mbr_pkg::OFS_STATUS) ? stat_m : 32'h0000_0000;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
			res_q    <= '0;
			ctrl_q   <= mbr_pkg::CTRL_RST;
			relay_q  <= mbr_pkg::RELAY_RST;
			dcmd_q   <= '0;
		end
		else
		begin
			if (arvalid && arready)
			begin
				rvalid_q <= 1'b1;
				rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
				rdata_q  <= rd_mux;
			end
			else if (rready)
				rvalid_q <= 1'b0;
			res_q   <= res_d;
			// masking every cycle also clears bits a profile change retires
			ctrl_q  <= ctrl_d & cmask;
			relay_q <= relay_d;
			dcmd_q  <= dcmd_d;
		end
	end

	assign control_word   = ctrl_q;
	assign relay_out      = relay_q;
	assign drive_cmd      = dcmd_q;
	assign active_profile = prof;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_force_relay;
		go_q && fc == mbr_pkg::FC_FORCE_COIL &&
			madr == mbr_pkg::RELAY_BASE && wd == mbr_pkg::COIL_ON;
	endsequence
	sequence s_write_ext17;
		go_q && fc == mbr_pkg::FC_WRITE_HREG && qty == mbr_pkg::ONE_QTY &&
			madr == mbr_pkg::HREG_CTRL_HI && wd[1] && is_ext;
	endsequence

	property p_force_coil_ok;
		go_q && fc == mbr_pkg::FC_FORCE_COIL && one_in &&
			(wd == mbr_pkg::COIL_ON || wd == mbr_pkg::COIL_OFF) |=>
			res_q.exc == mbr_pkg::EXC_NONE;
	endproperty
	a_force_coil_ok: assert property (p_force_coil_ok)
		else $error("valid single coil force was refused");
	property p_read_di;
		go_q && fc == mbr_pkg::FC_READ_DI && qty_ok && bits_in |=>
			res_q.data[0] == $past(din_img[madr[5:0]]);
	endproperty
	a_read_di: assert property (p_read_di)
		else $error("first discrete input read does not match its image");
	property p_read_ai2;
		go_q && fc == mbr_pkg::FC_READ_IREG && qty == mbr_pkg::ONE_QTY &&
			madr == 16'h0001 |=> res_q.data == $past(analog_in_two);
	endproperty
	a_read_ai2: assert property (p_read_ai2)
		else $error("input register 1 does not return analog input two");
	property p_hreg_write;
		go_q && fc == mbr_pkg::FC_WRITE_HREG && qty == mbr_pkg::ONE_QTY &&
			hr_in && !hr_stat |=>
			($past(hr_hi) ? ctrl_q[31:16] : ctrl_q[15:0]) ==
			$past(wd & (hr_hi ? cmask[31:16] : cmask[15:0]));
	endproperty
	a_hreg_write: assert property (p_hreg_write)
		else $error("holding register write did not reach control word");
	property p_prof_mask;
		prof == $past(prof) |-> (ctrl_q & ~cmask) == 32'h0000_0000;
	endproperty
	a_prof_mask: assert property (p_prof_mask)
		else $error("control word holds bits outside the active profile");
	property p_bypass;
		sys_set |-> prof == mbr_pkg::fixed_bypass_profile;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("system setting did not force the bypass profile");
	property p_default_prof;
		!sys_set && psel == mbr_pkg::PSEL_LIMITED |->
			prof == mbr_pkg::limited_std_profile;
	endproperty
	a_default_prof: assert property (p_default_prof)
		else $error("selector 0 did not give the limited profile");
	property p_ext_wide;
		s_write_ext17 |=> ctrl_q[17];
	endproperty
	a_ext_wide: assert property (p_ext_wide)
		else $error("extended profile lost control bit 17");
	property p_full_rampout;
		prof == mbr_pkg::full_std_profile &&
			$past(prof) == mbr_pkg::full_std_profile |->
			dcmd_q.ramp_out_zero == $past(ctrl_q[4]);
	endproperty
	a_full_rampout: assert property (p_full_rampout)
		else $error("full profile bit 4 not decoded as ramp-out zero");
	property p_relay_read;
		go_q && fc == mbr_pkg::FC_READ_COIL && qty_ok && bits_in &&
			madr == mbr_pkg::RELAY_BASE |=>
			res_q.data[0] == $past(relay_q[0]);
	endproperty
	a_relay_read: assert property (p_relay_read)
		else $error("message address 32 does not read relay one");
	property p_reserved_coils;
		ctrl_q[31:20] == 12'h000;
	endproperty
	a_reserved_coils: assert property (p_reserved_coils)
		else $error("reserved control bits are set");
	property p_relay_force;
		s_force_relay |=> relay_q[0] ##1 relay_out[0];
	endproperty
	a_relay_force: assert property (p_relay_force)
		else $error("forcing coil 33 did not set relay one");
	property p_limited_na;
		prof == mbr_pkg::limited_std_profile &&
			$past(prof) == mbr_pkg::limited_std_profile |->
			!ctrl_q[4] && !ctrl_q[10];
	endproperty
	a_limited_na: assert property (p_limited_na)
		else $error("limited profile keeps an inapplicable bit");

endmodule : mbr_reference_map

//--- verification/mbr_drive_model.sv
// drive-side stand-in: fixed status word, analog values and pin levels
module mbr_drive_model (
	output wire logic [31:0] status_word,
	output wire logic [15:0] analog_in_one,
	output wire logic [15:0] analog_in_two,
	output wire logic [5:0]  digital_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// distinct patterns so a swapped channel shows up
	assign status_word   = 32'hffff_ffff;
	assign analog_in_one = 16'h1234;
	assign analog_in_two = 16'h5678;
	assign digital_in    = 6'h2a;
endmodule : mbr_drive_model

//--- verification/tb_mbr_reference_map.sv
// self-checking bench for the modbus reference mapper
module tb_mbr_reference_map;
	timeunit 1ns;
	timeprecision 1ns;
	logic                    aclk = 1'h0;
	logic                    aresetn = 1'h0;
	logic                    awvalid = 1'h0;
	logic                    wvalid = 1'h0;
	logic                    arvalid = 1'h0;
	logic                    bready = 1'h1;
	logic                    rready = 1'h1;
	logic [7:0]              awaddr = 8'h00;
	logic [7:0]              araddr = 8'h00;
	logic [31:0]             wdata = 32'h0;
	logic [3:0]              wstrb = 4'hf;
	logic [31:0]             rdata, control_word, status_word, r;
	logic [1:0]              bresp, rresp, b;
	logic                    awready, wready, bvalid, arready, rvalid;
	logic [15:0]             analog_in_one, analog_in_two;
	logic [5:0]              digital_in, relay_out;
	mbr_pkg::mbr_drive_cmd_s drive_cmd;
	mbr_pkg::mbr_profile_e   active_profile;
	int                      mismatches = 0;
	int                      comparisons = 0;

	mbr_drive_model mbr_drive_model_i (.status_word, .analog_in_one,
		.analog_in_two, .digital_in);
	mbr_reference_map mbr_reference_map_i (.aclk, .aresetn, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .status_word, .analog_in_one, .analog_in_two,
		.digital_in, .control_word, .relay_out, .drive_cmd,
		.active_profile);

	initial
	begin
		forever #5 aclk = ~aclk;
	end

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e)
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		if (s !== e)
			mismatches++;
	endtask : chk

	// a wait that runs out of cycles ends the run as a failure
	task automatic hung(input int n);
		if (n >= 40)
			mismatches++;
		if (n >= 40)
			close_out;
	endtask : hung

	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] o);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		hung(n);
		o = bresp;
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] o);
		int n;
		araddr <= a;
		arvalid <= 1'h1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		hung(n);
		o = rdata;
	endtask : axr

	// one command through the registers; checks done flag and exception
	task automatic mb(input logic [7:0] fc, input logic [15:0] ad,
		input logic [4:0] q, input logic [31:0] d, input logic [7:0] ex,
		output logic [31:0] o);
		logic [1:0]  rs;
		logic [31:0] res;
		axw(8'h08, d, rs);
		axw(8'h04, {3'h0, q, ad, fc}, rs);
		axr(8'h0c, res);
		chk("result", {16'h0, res[31:16]}, {16'h0, 8'h80, ex});
		o = {16'h0, res[15:0]};
	endtask : mb

	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		mb(8'h0f, 16'h0, 5'h10, 32'hffff, 8'h0, r);
		chk("ctrl_lim", control_word, 32'h08ef);
		chk("cmd_lim", {9'h0, drive_cmd}, 32'h0079_c800);
		mb(8'h05, 16'h20, 5'h1, 32'hff00, 8'h0, r);
		chk("relay", {26'h0, relay_out}, 32'h1);
		mb(8'h01, 16'h20, 5'h6, 32'h0, 8'h0, r);
		chk("coils", r, 32'h1);
		mb(8'h08, 16'h0, 5'h1, 32'h0, 8'h1, r);
		mb(8'h01, 16'h21, 5'h6, 32'h0, 8'h2, r);
		mb(8'h02, 16'h20, 5'h6, 32'h0, 8'h0, r);
		chk("din", r, 32'h2a);
		mb(8'h04, 16'h1, 5'h1, 32'h0, 8'h0, r);
		chk("ai2", r, 32'h5678);
		axr(8'h14, r);
		chk("stat", r, 32'h1fff);
		axw(8'h00, 32'h2, b);
		chk("bresp_cfg", {30'h0, b}, 32'h0);
		mb(8'h0f, 16'h0, 5'h10, 32'hffff, 8'h0, r);
		axr(8'h10, r);
		chk("ctrl_full", r, 32'h0cff);
		axw(8'h00, 32'h1, b);
		mb(8'h06, 16'h1, 5'h1, 32'hffff, 8'h0, r);
		chk("ctrl_ext", control_word, 32'h000f_0cf7);
		chk("cmd_ext", {9'h0, drive_cmd}, 32'h007f_2e4f);
		mb(8'h03, 16'h1, 5'h1, 32'h0, 8'h0, r);
		chk("hreg", r, 32'h000f);
		axr(8'h14, r);
		chk("stat_ext", r, 32'hfc1f_ffff);
		axw(8'h00, 32'h5, b);
		@(posedge aclk);
		chk("prof", 32'(active_profile),
			32'(mbr_pkg::fixed_bypass_profile));
		chk("ctrl_byp", control_word, 32'h08e7);
		axw(8'h20, 32'h0, b);
		chk("unmapped", {30'h0, b}, 32'h2);
		axr(8'h20, r);
		chk("rd_unmapped", r, 32'h0);
		chk("rresp", {30'h0, rresp}, 32'h2);
		close_out;
	end
endmodule : tb_mbr_reference_map
